// ### mrac_core_model.sv
// Core pipeline model that issues one access at a time
module mrac_core_model (
  input wire logic clk,
  output logic accValid,
  output mrac_pkg::mrac_access_t access
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    accValid = 1'b0;
    access = '0;
  end

  // **********
  // Issue
  // **********
  // Held from one edge to the taking edge; fetches never write
  task automatic issue(input logic [31:0] a, input logic w, input logic f, input logic p);
    @(posedge clk);
    accValid <= 1'b1;
    access <= '{addr: a, write: w & ~f, fetch: f, priv: p};
    @(posedge clk);
    accValid <= 1'b0;
    // Released bus shows junk, not a stale request
    access <= ~access;
  endtask
endmodule // mrac_core_model

// ### mrac_pkg.sv
// Package for the region attribute and permission checker
package mrac_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_REGIONS = 8;
  localparam int REGION_IDX_W = 3;
  localparam int SUBREGION_CNT = 8;
  localparam int ADDR_W = 32;
  localparam logic [4:0] SIZE_MIN_SUB = 5'h07;
  localparam logic [4:0] SIZE_MAX = 5'h1f;
  localparam logic [5:0] SUB_SHIFT_OFS = 6'h02;

  // ****************************************
  // Attribute/size register layout
  // ****************************************
  localparam int XN_BIT = 28;
  localparam int AP_HI = 26;
  localparam int AP_LO = 24;
  localparam int TEX_HI = 21;
  localparam int TEX_LO = 19;
  localparam int SHR_BIT = 18;
  localparam int C_BIT = 17;
  localparam int B_BIT = 16;
  localparam int SRD_HI = 15;
  localparam int SRD_LO = 8;
  localparam int SIZE_HI = 5;
  localparam int SIZE_LO = 1;
  localparam int EN_BIT = 0;
  localparam logic [31:0] ATTR_WMASK = 32'h173fff3f;
  localparam logic [31:0] ATTR_RESET = 32'h00000000;
  localparam logic [1:0] HALF_LO = 2'h1;
  localparam logic [1:0] HALF_HI = 2'h2;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] TEX_LEGACY = 3'h0;
  localparam logic [2:0] TEX_NC = 3'h1;
  localparam logic [2:0] TEX_DEV = 3'h2;
  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_URO = 3'h2;
  localparam logic [2:0] AP_FULL = 3'h3;
  localparam logic [2:0] AP_RSVD = 3'h4;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;
  localparam logic [2:0] AP_RO_A = 3'h6;
  localparam logic [2:0] AP_RO_B = 3'h7;
  localparam logic [1:0] CP_NC = 2'h0;
  localparam logic [1:0] CP_WBRA = 2'h1;
  localparam logic [1:0] CP_WT = 2'h2;
  localparam logic [1:0] CP_WB = 2'h3;

  typedef enum logic [2:0] {
    MEM_STRONG, MEM_DEVICE, MEM_NORMAL, MEM_RESERVED, MEM_IMPDEF
  } mrac_memtype_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic fetch;
    logic priv;
  } mrac_access_t;

  typedef struct packed {
    mrac_memtype_t memType;
    logic shareable;
    logic [1:0] innerPol;
    logic [1:0] outerPol;
  } mrac_attr_t;

  typedef struct packed {
    logic hit;
    logic xnFault;
    logic apFault;
    logic [REGION_IDX_W-1:0] region;
  } mrac_result_t;
endpackage : mrac_pkg

// ### mrac_region_check.sv
// Region attribute/size registers, attribute decode and permission check
// ****************************************
// Overview
// ****************************************
// How it works
// - Word or halfword writes to attribute register
// - Execute-never bit blocks instruction fetches
// - Access permission field in bits 26:24
// - Type extension, C, B, shareable bit positions
// - Subregion disable flag set disables subregion
// - Region size is two to size plus one
// - Size plus one low address bits masked
// - Enable bit gates region address matching
// - Disallowed access in matched region faults
// - Type extension 000 legacy decode
// - Type extension 001 decode
// - Type extension 010 device, shareable ignored
// - Top type bit selects cached normal memory
// - Two-bit cache policy decode
// - Permissions 000 to 011 decode
// - Permissions 101 to 111, 100 reserved
// - Violation raises fault and records cause
// - Eight subregions, low flag lowest subregion
// - Register acts on selected region 0 to 7
module mrac_region_check (
  input wire logic clk,
  input wire logic srst,
  input wire logic [mrac_pkg::REGION_IDX_W-1:0] regionNumberSelect,
  input wire logic [mrac_pkg::ADDR_W-1:0] regionBaseAddr [mrac_pkg::NUM_REGIONS],
  input wire logic attrWrite,
  input wire logic [1:0] attrHalfEn,
  input wire logic [31:0] attrWdata,
  output logic [31:0] attrRdata,
  input wire logic accValid,
  input wire mrac_pkg::mrac_access_t access,
  output logic faultPulse,
  output logic [1:0] memfaultStatus,
  output logic accHit,
  output mrac_pkg::mrac_attr_t accAttr
);
  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] attrReg [mrac_pkg::NUM_REGIONS];
  logic [31:0] attrNext [mrac_pkg::NUM_REGIONS];
  logic [31:0] laneMask;

  assign laneMask = {{16{attrHalfEn[1]}}, {16{attrHalfEn[0]}}} & mrac_pkg::ATTR_WMASK;

  genvar gi;
  generate
    for (gi = 0; gi < mrac_pkg::NUM_REGIONS; gi++) begin : gRegs
      assign attrNext[gi] =
        (attrWrite && regionNumberSelect == mrac_pkg::REGION_IDX_W'(gi)) ?
        ((attrReg[gi] & ~laneMask) | (attrWdata & laneMask)) : attrReg[gi];
      always_ff @(posedge clk) begin
        if (srst) begin
          attrReg[gi] <= mrac_pkg::ATTR_RESET;
        end else begin
          attrReg[gi] <= attrNext[gi];
        end
      end
    end
  endgenerate

  logic [31:0] attrRdata_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      attrRdata_reg <= mrac_pkg::ATTR_RESET;
    end else begin
      attrRdata_reg <= attrNext[regionNumberSelect] & mrac_pkg::ATTR_WMASK;
    end
  end
  assign attrRdata = attrRdata_reg;

  // ****************************************
  // Decode functions
  // ****************************************
  // Region span mask
  function automatic logic [mrac_pkg::ADDR_W-1:0] spanMask(input logic [4:0] sz);
    logic [5:0] bits;
    bits = 6'(sz) + 6'h01;
    spanMask = (bits >= 6'(mrac_pkg::ADDR_W)) ? '1 : ((32'h1 << bits) - 32'h1);
  endfunction

  function automatic mrac_pkg::mrac_attr_t decodeAttr(input logic [31:0] r);
    logic [2:0] type_extension;
    logic [1:0] cb;
    logic s;
    mrac_pkg::mrac_attr_t a;
    type_extension = r[mrac_pkg::TEX_HI:mrac_pkg::TEX_LO];
    cb = {r[mrac_pkg::C_BIT], r[mrac_pkg::B_BIT]};
    s = r[mrac_pkg::SHR_BIT];
    a = '{mrac_pkg::MEM_RESERVED, 1'b0, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
    if (type_extension[2]) begin
      a = '{mrac_pkg::MEM_NORMAL, s, cb, type_extension[1:0]};
    end else if (type_extension == mrac_pkg::TEX_LEGACY) begin
      unique case (cb)
        2'h0: a = '{mrac_pkg::MEM_STRONG, 1'b1, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
        2'h1: a = '{mrac_pkg::MEM_DEVICE, 1'b1, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
        2'h2: a = '{mrac_pkg::MEM_NORMAL, s, mrac_pkg::CP_WT, mrac_pkg::CP_WT};
        2'h3: a = '{mrac_pkg::MEM_NORMAL, s, mrac_pkg::CP_WB, mrac_pkg::CP_WB};
      endcase
    end else if (type_extension == mrac_pkg::TEX_NC) begin
      unique case (cb)
        2'h0: a = '{mrac_pkg::MEM_NORMAL, s, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
        2'h1: a = '{mrac_pkg::MEM_RESERVED, 1'b0, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
        2'h2: a = '{mrac_pkg::MEM_IMPDEF, 1'b0, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
        2'h3: a = '{mrac_pkg::MEM_NORMAL, s, mrac_pkg::CP_WBRA, mrac_pkg::CP_WBRA};
      endcase
    end else if (type_extension == mrac_pkg::TEX_DEV && cb == 2'h0) begin
      a = '{mrac_pkg::MEM_DEVICE, 1'b0, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
    end
    decodeAttr = a;
  endfunction

  function automatic logic apAllows(input logic [2:0] ap, input logic priv,
                                    input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (ap)
      mrac_pkg::AP_NONE: ok = 1'b0;
      mrac_pkg::AP_PRIV_RW: ok = priv;
      mrac_pkg::AP_URO: ok = priv | ~wr;
      mrac_pkg::AP_FULL: ok = 1'b1;
      mrac_pkg::AP_RSVD: ok = 1'b0;
      mrac_pkg::AP_PRIV_RO: ok = priv & ~wr;
      mrac_pkg::AP_RO_A, mrac_pkg::AP_RO_B: ok = ~wr;
    endcase
    apAllows = ok;
  endfunction

  // ****************************************
  // Region matching
  // ****************************************
  logic [mrac_pkg::NUM_REGIONS-1:0] regHit;
  generate
    for (gi = 0; gi < mrac_pkg::NUM_REGIONS; gi++) begin : gMatch
      logic [4:0] sz;
      logic [mrac_pkg::ADDR_W-1:0] msk;
      logic inRegion;
      logic [2:0] subIdx;
      logic subOn;
      assign sz = attrReg[gi][mrac_pkg::SIZE_HI:mrac_pkg::SIZE_LO];
      assign msk = spanMask(sz);
      // Base assumed aligned, low bits ignored
      assign inRegion = ((access.addr & ~msk) == (regionBaseAddr[gi] & ~msk));
      // Subregion index from top three offset bits
      assign subIdx = (sz == mrac_pkg::SIZE_MAX) ? access.addr[31:29] :
        3'(access.addr >> (6'(sz) - mrac_pkg::SUB_SHIFT_OFS));
      // Small regions take no subregion flags
      assign subOn = (sz < mrac_pkg::SIZE_MIN_SUB) ||
        !attrReg[gi][mrac_pkg::SRD_LO + 32'(subIdx)];
      assign regHit[gi] = attrReg[gi][mrac_pkg::EN_BIT] && inRegion && subOn;
    end
  endgenerate

  // Highest numbered region wins on overlap
  logic [mrac_pkg::REGION_IDX_W-1:0] winIdx;
  always_comb begin
    winIdx = '0;
    for (int i = 0; i < mrac_pkg::NUM_REGIONS; i++) begin
      if (regHit[i]) begin
        winIdx = mrac_pkg::REGION_IDX_W'(i);
      end
    end
  end

  // ****************************************
  // Permission check
  // ****************************************
  logic anyHit;
  logic [31:0] winReg;
  logic xnBlock;
  logic apBlock;
  assign anyHit = |regHit;
  assign winReg = attrReg[winIdx];
  assign xnBlock = access.fetch && winReg[mrac_pkg::XN_BIT];
  // Permission field read from bits 26:24
  assign apBlock = !apAllows(winReg[mrac_pkg::AP_HI:mrac_pkg::AP_LO], access.priv,
    access.write);

  logic faultPulse_reg;
  logic [1:0] memfaultStatus_reg;
  logic accHit_reg;
  mrac_pkg::mrac_attr_t accAttr_reg;
  logic faultNow;
  assign faultNow = accValid && anyHit && (xnBlock || apBlock);

  always_ff @(posedge clk) begin
    if (srst) begin
      faultPulse_reg <= 1'b0;
      memfaultStatus_reg <= 2'h0;
      accHit_reg <= 1'b0;
      accAttr_reg <= '{mrac_pkg::MEM_STRONG, 1'b0, mrac_pkg::CP_NC, mrac_pkg::CP_NC};
    end else begin
      faultPulse_reg <= faultNow;
      if (faultNow) begin
        memfaultStatus_reg <= {xnBlock, apBlock & ~xnBlock};
      end
      accHit_reg <= accValid && anyHit;
      if (accValid) begin
        accAttr_reg <= decodeAttr(winReg);
      end
    end
  end
  assign faultPulse = faultPulse_reg;
  assign memfaultStatus = memfaultStatus_reg;
  assign accHit = accHit_reg;
  assign accAttr = accAttr_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_fetch_xn_fault: assert property (
    @(posedge clk) disable iff (srst)
    accValid && anyHit && access.fetch && winReg[mrac_pkg::XN_BIT] |=> faultPulse
  ) else $error("execute-never fetch did not fault");

  a_nohit_no_fault: assert property (
    @(posedge clk) disable iff (srst)
    !(accValid && anyHit) |=> !faultPulse
  ) else $error("fault without matched region");

  a_full_ap_ok: assert property (
    @(posedge clk) disable iff (srst)
    accValid && anyHit && !access.fetch &&
    winReg[mrac_pkg::AP_HI:mrac_pkg::AP_LO] == mrac_pkg::AP_FULL |=> !faultPulse
  ) else $error("full access faulted");

  a_ro_write_fault: assert property (
    @(posedge clk) disable iff (srst)
    accValid && anyHit && access.write &&
    winReg[mrac_pkg::AP_HI:mrac_pkg::AP_LO] == mrac_pkg::AP_RO_A |=> faultPulse
  ) else $error("write to read-only not faulted");

  a_cause_recorded: assert property (
    @(posedge clk) disable iff (srst)
    faultPulse |-> memfaultStatus != 2'h0
  ) else $error("fault without cause");

  a_rsvd_read_zero: assert property (
    @(posedge clk) disable iff (srst)
    (attrRdata & ~mrac_pkg::ATTR_WMASK) == 32'h0
  ) else $error("reserved bits nonzero");

  a_disabled_no_hit: assert property (
    @(posedge clk) disable iff (srst)
    (attrReg[0][mrac_pkg::EN_BIT] == 1'b0) |-> !regHit[0]
  ) else $error("disabled region matched");

  a_half_write_kept: assert property (
    @(posedge clk) disable iff (srst)
    attrWrite && attrHalfEn == mrac_pkg::HALF_LO |=>
    attrReg[$past(regionNumberSelect)][31:16] == $past(attrReg[regionNumberSelect][31:16])
  ) else $error("upper half changed by low halfword write");
endmodule : mrac_region_check

// ### tb.sv
// Self-checking bench for the region attribute checker
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, attrWrite, accValid, faultPulse, accHit;
  logic [2:0] regionNumberSelect, t;
  logic [31:0] regionBaseAddr [8];
  logic [31:0] shadow [8];
  logic [31:0] attrWdata, attrRdata, bs, d;
  logic [1:0] attrHalfEn, memfaultStatus, stat;
  mrac_pkg::mrac_access_t access;
  mrac_pkg::mrac_attr_t accAttr, ea;
  int badCount = 0;
  int compares = 0;
  int cyc = 0;
  int k;

  mrac_region_check mrac_region_check_inst (.clk(clk), .srst(srst),
    .regionNumberSelect(regionNumberSelect), .regionBaseAddr(regionBaseAddr),
    .attrWrite(attrWrite), .attrHalfEn(attrHalfEn), .attrWdata(attrWdata),
    .attrRdata(attrRdata), .accValid(accValid), .access(access),
    .faultPulse(faultPulse), .memfaultStatus(memfaultStatus), .accHit(accHit),
    .accAttr(accAttr));
  mrac_core_model mrac_core_model_inst (.clk(clk), .accValid(accValid), .access(access));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // **********
  // Helpers
  // **********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (badCount == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wreg(input logic [2:0] r, input logic [1:0] h, input logic [31:0] v);
    @(posedge clk);
    regionNumberSelect <= r;
    attrWrite <= 1'b1;
    attrHalfEn <= h;
    attrWdata <= v;
    @(posedge clk);
    attrWrite <= 1'b0;
    attrWdata <= ~v;
  endtask

  task automatic rd(input logic [2:0] r);
    @(posedge clk);
    regionNumberSelect <= r;
    @(posedge clk);
    #1;
    chk(attrRdata, shadow[r]);
  endtask

  // Status is sticky, so the bench tracks the last fault code
  task automatic acc(input logic [31:0] a, input logic [2:0] wfp, input logic hit,
                     input logic [1:0] code);
    mrac_core_model_inst.issue(a, wfp[2], wfp[1], wfp[0]);
    #1;
    if (code != 2'h0) stat = code;
    chk({28'h0, accHit, faultPulse, memfaultStatus}, {28'h0, hit, code != 2'h0, stat});
  endtask

  function automatic logic apOk(input logic [2:0] ap, input logic p, input logic w);
    case (ap)
      3'h1: return p;
      3'h2: return p | ~w;
      3'h3: return 1'b1;
      3'h5: return p & ~w;
      3'h6, 3'h7: return ~w;
      default: return 1'b0;
    endcase
  endfunction

  function automatic mrac_pkg::mrac_attr_t expAttr(input logic [2:0] tx, input logic [2:0] scb);
    expAttr = '{mrac_pkg::MEM_NORMAL, scb[2], scb[1:0], scb[1:0]};
    if (tx[2]) expAttr.outerPol = tx[1:0];
    else if (tx == 3'h0 && !scb[1])
      expAttr = '{scb[0] ? mrac_pkg::MEM_DEVICE : mrac_pkg::MEM_STRONG, 1'b1, 2'h0, 2'h0};
    else if (tx == 3'h0) expAttr.shareable = scb[2];
    else if (tx == 3'h1 && scb[1] == scb[0])
      expAttr = '{mrac_pkg::MEM_NORMAL, scb[2], {1'b0, scb[1]}, {1'b0, scb[1]}};
    else if (tx == 3'h1 && scb[1]) expAttr.memType = mrac_pkg::MEM_IMPDEF;
    else if (tx == 3'h2 && scb[1:0] == 2'h0)
      expAttr = '{mrac_pkg::MEM_DEVICE, 1'b0, 2'h0, 2'h0};
    else expAttr = '{mrac_pkg::MEM_RESERVED, 1'b0, 2'h0, 2'h0};
  endfunction

  // Random register words kept within what software may program
  function automatic logic [31:0] legalize(input logic [31:0] v);
    if (v[5:1] < 5'h04) v[5:1] = 5'h04;
    if (v[5:1] < 5'h07) v[15:8] = 8'h00;
    return v;
  endfunction

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      badCount++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  // **********
  // Sequence
  // **********
  initial begin
    srst = 1'b1;
    attrWrite = 1'b0;
    attrHalfEn = 2'h0;
    attrWdata = 32'h0;
    regionNumberSelect = 3'h0;
    stat = 2'h0;
    void'($urandom(91));
    bs = $urandom & 32'hfffffc00;
    for (k = 0; k < 8; k++) regionBaseAddr[k] = bs;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(attrRdata, 32'h0);
    for (k = 0; k < 8; k++) begin
      d = legalize($urandom);
      wreg(k[2:0], 2'h3, d);
      shadow[k] = d & mrac_pkg::ATTR_WMASK;
    end
    d = legalize($urandom);
    wreg(3'h2, 2'h1, d);
    shadow[2] = {shadow[2][31:16], d[15:0]} & mrac_pkg::ATTR_WMASK;
    d = legalize($urandom);
    wreg(3'h5, 2'h2, d);
    shadow[5] = {d[31:16], shadow[5][15:0]} & mrac_pkg::ATTR_WMASK;
    for (k = 0; k < 8; k++) begin
      rd(k[2:0]);
      wreg(k[2:0], 2'h3, 32'h0);
    end
    wreg(3'h0, 2'h3, 32'h03020013);
    acc(bs + 32'h3ff, 3'h1, 1'b1, 2'h0);
    acc(bs + 32'h400, 3'h1, 1'b0, 2'h0);
    wreg(3'h7, 2'h3, 32'h0300003f);
    acc($urandom, 3'h5, 1'b1, 2'h0);
    wreg(3'h7, 2'h1, 32'h0);
    wreg(3'h0, 2'h1, 32'h12);
    acc(bs, 3'h1, 1'b0, 2'h0);
    k = $urandom_range(7);
    wreg(3'h0, 2'h1, 32'h13 | (32'h100 << k));
    acc(bs + (32'(k) << 7), 3'h1, 1'b0, 2'h0);
    acc(bs + (32'((k + 1) % 8) << 7), 3'h1, 1'b1, 2'h0);
    wreg(3'h0, 2'h1, 32'h0d);
    acc(bs + 32'h7f, 3'h1, 1'b1, 2'h0);
    acc(bs + 32'h80, 3'h1, 1'b0, 2'h0);
    wreg(3'h0, 2'h1, 32'h13);
    for (k = 0; k < 32; k++) begin
      wreg(3'h0, 2'h2, {5'h0, k[4:2], 8'h02, 16'h0});
      acc(bs + ($urandom & 32'h3fc), {k[1], 1'b0, k[0]}, 1'b1,
          apOk(k[4:2], k[0], k[1]) ? 2'h0 : 2'h1);
    end
    wreg(3'h0, 2'h2, 32'h13020000);
    acc(bs, 3'h3, 1'b1, 2'h2);
    wreg(3'h0, 2'h2, 32'h03020000);
    acc(bs, 3'h2, 1'b1, 2'h0);
    wreg(3'h0, 2'h2, 32'h01020000);
    acc(bs, 3'h2, 1'b1, 2'h1);
    for (k = 0; k < 64; k++) begin
      {t, d[2:0]} = k[5:0];
      wreg(3'h0, 2'h2, {8'h03, 2'h0, t, d[2:0], 16'h0});
      acc(bs, 3'h1, 1'b1, 2'h0);
      ea = expAttr(t, d[2:0]);
      if (ea.memType == mrac_pkg::MEM_NORMAL) chk({24'h0, accAttr}, {24'h0, ea});
      else if (ea.memType != mrac_pkg::MEM_IMPDEF)
        chk({28'h0, accAttr[7:4]}, {28'h0, ea[7:4]});
      else chk({29'h0, accAttr[7:5]}, {29'h0, ea[7:5]});
    end
    // Mid-run reset clears registers and sticky status
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(attrRdata, 32'h0);
    chk({24'h0, accAttr}, 32'h0);
    chk({28'h0, accHit, faultPulse, memfaultStatus}, 32'h0);
    stat = 2'h0;
    acc(bs, 3'h1, 1'b0, 2'h0);
    wrap_up();
  end
endmodule // tb
